//--- rtl/spu_uart.v
// Four-mode serial port with its transmit FIFO
//
// How it works
// - Two mode bits select one of four modes
// - Shift mode: data on rxd, clock at core/12
// - Buffer write starts transmit; shift mode LSB first
// - Shift receive starts when enabled and flag clear
// - 8-bit frame: start, eight data LSB first, stop
// - Stop bit ninth; transmit flag at stop bit
// - Async receive starts on falling rxd edge
// - Extended off: accept only with receive flag clear
// - 8-bit mode with filter: stop must be one
// - Failed check drops frame, receive flag untouched
// - 8-bit accept: buffer, stop bit, set flag
// - 9-bit frame: start, eight data, ninth, stop
// - Fixed 9-bit rate core times double-bit over 32
// - 9-bit send loads ninth bit, waits baud tick
// - 9-bit with filter: accept only ninth bit set
// - 9-bit accept: buffer, ninth bit, set flag
// - Mode three equals mode two with timer rate
// - Variable rate from timers; directions independent
// - Timer 1 rate times double-bit over 32
// - Timer 2 rate divided by sixteen
// - Clock select bits pick Timer 2 per direction
// - Config bit turns on extended feature
// - Extended, async modes: overwrite, flag error, clear on read
`timescale 1ns/100ps
`default_nettype none
`include "spu_map.vh"

module spu_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             rst_b,
    // Filling side
    input  wire             in_valid,
    input  wire [WIDTH-1:0] in_data,
    output reg              in_ready_reg,
    // Draining side
    output reg              out_valid_reg,
    output wire [WIDTH-1:0] out_data,
    input  wire             out_ready
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wptr_reg;
    reg  [AW-1:0]    rptr_reg;
    reg  [AW:0]      count_reg;
    wire             push;
    wire             pop;
    wire [AW:0]      count_next;

    assign push       = in_valid & in_ready_reg;
    assign pop        = out_valid_reg & out_ready;
    assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_data   = mem[rptr_reg];

    always @(posedge ref_clk) begin
        if (push) begin
            mem[wptr_reg] <= in_data;
        end
    end

    // Flags come from flops so the drained side sees no comb path through count
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wptr_reg      <= {AW{1'b0}};
            rptr_reg      <= {AW{1'b0}};
            count_reg     <= {(AW+1){1'b0}};
            in_ready_reg  <= 1'b0;
            out_valid_reg <= 1'b0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rptr_reg <= rptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            count_reg     <= count_next;
            in_ready_reg  <= (count_next != DEPTH[AW:0]);
            out_valid_reg <= (count_next != {(AW+1){1'b0}});
        end
    end
endmodule // spu_fifo

module spu_uart (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       rst_b,
    // Register port
    input  wire [7:0] sfr_addr,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_wr,
    input  wire       sfr_rd,
    output reg  [7:0] sfr_rdata_reg,
    // Transmit queue state and receive overwrite error
    output wire       tx_ready,
    output reg        overwrite_err_reg,
    // Baud sources, core clock domain
    input  wire       timer1_ovf,
    input  wire       timer2_ovf,
    // Serial pins
    input  wire       rxd_in,
    output reg        rxd_out_reg,
    output reg        rxd_oe_reg,
    output reg        txd_reg
);
    localparam TX_IDLE  = 2'b00;
    localparam TX_WAIT  = 2'b01;
    localparam TX_SHIFT = 2'b10;
    localparam TX_M0    = 2'b11;
    localparam RX_IDLE  = 2'b00;
    localparam RX_START = 2'b01;
    localparam RX_DATA  = 2'b10;
    localparam RX_M0    = 2'b11;

    reg  [7:0]  ctrl_reg;
    reg  [7:0]  pwr_reg;
    reg  [7:0]  t2ctrl_reg;
    reg         ext_en_reg;
    reg  [7:0]  rxbuf_reg;
    reg  [1:0]  tx_state_reg;
    reg  [1:0]  rx_state_reg;
    reg  [10:0] tx_sh_reg;
    reg  [8:0]  rx_sh_reg;
    reg  [3:0]  tx_sub_reg;
    reg  [3:0]  rx_sub_reg;
    reg  [3:0]  tx_idx_reg;
    reg  [3:0]  rx_idx_reg;
    reg  [3:0]  m0_cnt_reg;
    reg         half_reg;
    reg         t1_half_reg;
    reg         rxd_s1_reg;
    reg         rxd_s2_reg;
    reg         rxd_s3_reg;
    wire [1:0]  mode;
    wire        m0_end;
    wire        t1_tick;
    wire        m2_tick;
    wire        tx_tick;
    wire        rx_tick;
    wire [3:0]  tx_last;
    wire        f_valid;
    wire [7:0]  f_data;
    wire        tx_take;
    wire        buf_wr;
    wire        rx_ok;
    wire        sync_in;

    assign mode    = {ctrl_reg[`SPU_CTRL_MODE_HI], ctrl_reg[`SPU_CTRL_MODE_LO]};
    assign m0_end  = (m0_cnt_reg == `SPU_M0_LAST);
    // Each tick is one sixteenth of a bit
    assign m2_tick = pwr_reg[`SPU_PWR_DOUBLE] | half_reg;
    assign t1_tick = timer1_ovf & (pwr_reg[`SPU_PWR_DOUBLE] | t1_half_reg);
    assign tx_tick = (mode == 2'b10) ? m2_tick :
                     (t2ctrl_reg[`SPU_T2_TXCLK] ? timer2_ovf : t1_tick);
    assign rx_tick = (mode == 2'b10) ? m2_tick :
                     (t2ctrl_reg[`SPU_T2_RXCLK] ? timer2_ovf : t1_tick);
    assign tx_last = (mode == 2'b01) ? 4'h9 : 4'hA;
    assign buf_wr  = sfr_wr & (sfr_addr == `SPU_ADDR_BUF);
    // Shift mode shares the clock pin, so transmit waits for the receiver
    assign tx_take = f_valid & (tx_state_reg == TX_IDLE) &
                     ((mode != 2'b00) | (m0_end & (rx_state_reg == RX_IDLE)));
    // Receive flag gate applies only with the extended feature off
    assign rx_ok   = (ext_en_reg | ~ctrl_reg[`SPU_CTRL_RXFLAG]) &
                     (~ctrl_reg[`SPU_CTRL_MPFILT] | rxd_s2_reg);
    assign sync_in = rxd_s2_reg;

    spu_fifo #(
        .WIDTH (8),
        .DEPTH (`SPU_FIFO_DEPTH),
        .AW    (`SPU_FIFO_AW)
    ) u_txq (
        .ref_clk       (ref_clk),
        .rst_b         (rst_b),
        .in_valid      (buf_wr),
        .in_data       (sfr_wdata),
        .in_ready_reg  (tx_ready),
        .out_valid_reg (f_valid),
        .out_data      (f_data),
        .out_ready     (tx_take)
    );

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg          <= `SPU_RESET_BYTE;
            pwr_reg           <= `SPU_RESET_BYTE;
            t2ctrl_reg        <= `SPU_RESET_BYTE;
            ext_en_reg        <= 1'b0;
            rxbuf_reg         <= `SPU_RESET_BYTE;
            sfr_rdata_reg     <= `SPU_RESET_BYTE;
            overwrite_err_reg <= 1'b0;
            tx_state_reg      <= TX_IDLE;
            rx_state_reg      <= RX_IDLE;
            tx_sh_reg         <= 11'h7FF;
            rx_sh_reg         <= 9'h000;
            tx_sub_reg        <= 4'h0;
            rx_sub_reg        <= 4'h0;
            tx_idx_reg        <= 4'h0;
            rx_idx_reg        <= 4'h0;
            m0_cnt_reg        <= 4'h0;
            half_reg          <= 1'b0;
            t1_half_reg       <= 1'b0;
            rxd_s1_reg        <= 1'b1;
            rxd_s2_reg        <= 1'b1;
            rxd_s3_reg        <= 1'b1;
            rxd_out_reg       <= 1'b1;
            rxd_oe_reg        <= 1'b0;
            txd_reg           <= 1'b1;
        end else begin
            rxd_s1_reg  <= rxd_in;
            rxd_s2_reg  <= rxd_s1_reg;
            rxd_s3_reg  <= rxd_s2_reg;
            half_reg    <= ~half_reg;
            m0_cnt_reg  <= m0_end ? 4'h0 : m0_cnt_reg + 4'h1;
            if (timer1_ovf) begin
                t1_half_reg <= ~t1_half_reg;
            end

            // Software accesses come first so hardware flag sets below win
            if (sfr_wr) begin
                case (sfr_addr)
                    `SPU_ADDR_CTRL:   ctrl_reg   <= sfr_wdata;
                    `SPU_ADDR_PWR:    pwr_reg    <= sfr_wdata;
                    `SPU_ADDR_T2CTRL: t2ctrl_reg <= sfr_wdata;
                    `SPU_ADDR_CFG:    ext_en_reg <= sfr_wdata[`SPU_CFG_EXT_EN];
                    default: ;
                endcase
            end
            if (sfr_rd) begin
                case (sfr_addr)
                    `SPU_ADDR_CTRL:   sfr_rdata_reg <= ctrl_reg;
                    `SPU_ADDR_PWR:    sfr_rdata_reg <= pwr_reg;
                    `SPU_ADDR_T2CTRL: sfr_rdata_reg <= t2ctrl_reg;
                    `SPU_ADDR_BUF:    sfr_rdata_reg <= rxbuf_reg;
                    `SPU_ADDR_CFG:    sfr_rdata_reg <= {overwrite_err_reg, 6'h00, ext_en_reg};
                    default:          sfr_rdata_reg <= 8'h00;
                endcase
                if (sfr_addr == `SPU_ADDR_BUF) begin
                    overwrite_err_reg <= 1'b0;
                end
            end

            // Transmitter
            case (tx_state_reg)
                TX_IDLE: begin
                    if (tx_take) begin
                        tx_idx_reg <= 4'h0;
                        tx_sub_reg <= 4'h0;
                        if (mode == 2'b00) begin
                            tx_sh_reg    <= {3'h7, f_data};
                            tx_state_reg <= TX_M0;
                        end else begin
                            tx_sh_reg    <= {1'b1, ((mode == 2'b01) |
                                             ctrl_reg[`SPU_CTRL_TX9]), f_data, 1'b0};
                            tx_state_reg <= TX_WAIT;
                        end
                    end
                end
                TX_WAIT: begin
                    if (tx_tick) begin
                        txd_reg      <= tx_sh_reg[0];
                        tx_state_reg <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tx_tick) begin
                        tx_sub_reg <= tx_sub_reg + 4'h1;
                        if (tx_sub_reg == `SPU_OVS_LAST) begin
                            if (tx_idx_reg == tx_last) begin
                                tx_state_reg <= TX_IDLE;
                            end else begin
                                tx_idx_reg <= tx_idx_reg + 4'h1;
                                tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
                                txd_reg    <= tx_sh_reg[1];
                                if (tx_idx_reg + 4'h1 == tx_last) begin
                                    ctrl_reg[`SPU_CTRL_TXFLAG] <= 1'b1;
                                end
                            end
                        end
                    end
                end
                TX_M0: begin
                    if (m0_cnt_reg == 4'h0) begin
                        rxd_oe_reg  <= 1'b1;
                        rxd_out_reg <= tx_sh_reg[0];
                        tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
                        txd_reg     <= 1'b0;
                    end else if (m0_cnt_reg == `SPU_M0_HALF) begin
                        txd_reg <= 1'b1;
                    end else if (m0_end) begin
                        tx_idx_reg <= tx_idx_reg + 4'h1;
                        if (tx_idx_reg == 4'h7) begin
                            rxd_oe_reg                 <= 1'b0;
                            rxd_out_reg                <= 1'b1;
                            ctrl_reg[`SPU_CTRL_TXFLAG] <= 1'b1;
                            tx_state_reg               <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase

            // Receiver
            case (rx_state_reg)
                RX_IDLE: begin
                    rx_sub_reg <= 4'h0;
                    rx_idx_reg <= 4'h0;
                    if (ctrl_reg[`SPU_CTRL_RXEN]) begin
                        if (mode != 2'b00) begin
                            if (rxd_s3_reg & ~sync_in) begin
                                rx_state_reg <= RX_START;
                            end
                        end else if (~ctrl_reg[`SPU_CTRL_RXFLAG] & m0_end &
                                     (tx_state_reg == TX_IDLE) & ~f_valid) begin
                            rx_state_reg <= RX_M0;
                        end
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        rx_sub_reg <= rx_sub_reg + 4'h1;
                        if (rx_sub_reg == `SPU_OVS_MID) begin
                            rx_sub_reg   <= 4'h0;
                            // A glitch shorter than half a bit is not a start
                            rx_state_reg <= sync_in ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rx_sub_reg <= rx_sub_reg + 4'h1;
                        if (rx_sub_reg == `SPU_OVS_LAST) begin
                            rx_sh_reg  <= {sync_in, rx_sh_reg[8:1]};
                            rx_idx_reg <= rx_idx_reg + 4'h1;
                            if (rx_idx_reg == 4'h8) begin
                                rx_state_reg <= RX_IDLE;
                                if (rx_ok) begin
                                    rxbuf_reg                  <= rx_sh_reg[8:1];
                                    ctrl_reg[`SPU_CTRL_RX9]    <= sync_in;
                                    ctrl_reg[`SPU_CTRL_RXFLAG] <= 1'b1;
                                    if (ctrl_reg[`SPU_CTRL_RXFLAG]) begin
                                        overwrite_err_reg <= 1'b1;
                                    end
                                end
                            end
                        end
                    end
                end
                RX_M0: begin
                    if (m0_cnt_reg == 4'h0) begin
                        txd_reg <= 1'b0;
                    end else if (m0_cnt_reg == `SPU_M0_HALF) begin
                        txd_reg   <= 1'b1;
                        rx_sh_reg <= {sync_in, rx_sh_reg[8:1]};
                    end else if (m0_end) begin
                        rx_idx_reg <= rx_idx_reg + 4'h1;
                        if (rx_idx_reg == 4'h7) begin
                            rxbuf_reg                  <= rx_sh_reg[8:1];
                            ctrl_reg[`SPU_CTRL_RXFLAG] <= 1'b1;
                            rx_state_reg               <= RX_IDLE;
                        end
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end
endmodule // spu_uart
`default_nettype wire

//--- rtl/spu_map.vh
// Register addresses, field positions, reset values and timing counts of the serial port
`ifndef SPU_MAP_VH
`define SPU_MAP_VH

`define SPU_ADDR_PWR         8'h87
`define SPU_ADDR_CTRL        8'h98
`define SPU_ADDR_BUF         8'h99
`define SPU_ADDR_CFG         8'hAF
`define SPU_ADDR_T2CTRL      8'hC8

`define SPU_CTRL_MODE_HI     7
`define SPU_CTRL_MODE_LO     6
`define SPU_CTRL_MPFILT      5
`define SPU_CTRL_RXEN        4
`define SPU_CTRL_TX9         3
`define SPU_CTRL_RX9         2
`define SPU_CTRL_TXFLAG      1
`define SPU_CTRL_RXFLAG      0
`define SPU_PWR_DOUBLE       7
`define SPU_T2_RXCLK         5
`define SPU_T2_TXCLK         4
`define SPU_CFG_OVERWRITE    7
`define SPU_CFG_EXT_EN       0

`define SPU_RESET_BYTE       8'h00

`define SPU_M0_DIV           4'hC
`define SPU_M0_LAST          (`SPU_M0_DIV - 4'h1)
`define SPU_M0_HALF          (`SPU_M0_DIV >> 1)
`define SPU_OVS_LAST         4'hF
`define SPU_OVS_MID          4'h7
`define SPU_FIFO_DEPTH       16
`define SPU_FIFO_AW          4

`endif

//--- tb/spu_uart_checker.sv
// Assertion checker for the serial port top, with its bind
`timescale 1ns/100ps
`default_nettype none
`include "spu_map.vh"
module spu_uart_checker (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_b,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata_reg,
    // Status and pins
    input wire logic       overwrite_err_reg,
    input wire logic       rxd_oe_reg,
    input wire logic       txd_reg
);
    // Shadow of control bits from register writes; hardware never alters these
    logic [1:0] mode_q;
    logic       rxen_q;
    logic       dbl_q;
    logic       ext_q;
    logic       t2tx_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= 2'h0;
            rxen_q <= 1'b0;
            dbl_q  <= 1'b0;
            ext_q  <= 1'b0;
            t2tx_q <= 1'b0;
        end else if (sfr_wr) begin
            case (sfr_addr)
                `SPU_ADDR_CTRL: begin
                    mode_q <= sfr_wdata[7:6];
                    rxen_q <= sfr_wdata[4];
                end
                `SPU_ADDR_PWR: dbl_q <= sfr_wdata[7];
                `SPU_ADDR_CFG: ext_q <= sfr_wdata[0];
                `SPU_ADDR_T2CTRL: t2tx_q <= sfr_wdata[4];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    property p_oe_mode; rxd_oe_reg |-> mode_q == 2'h0; endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("pin driven outside shift mode");
    property p_shift_clk; $fell(txd_reg) && mode_q == 2'h0 |-> (!txd_reg) [*6] ##1 txd_reg; endproperty
    a_shift_clk: assert property (p_shift_clk) else $error("shift clock phase wrong");
    property p_oe_start; $rose(rxd_oe_reg) |-> !txd_reg; endproperty
    a_oe_start: assert property (p_oe_start) else $error("shift out without clock");
    property p_rx0_gate; $fell(txd_reg) && mode_q == 2'h0 && !rxd_oe_reg |-> rxen_q; endproperty
    a_rx0_gate: assert property (p_rx0_gate) else $error("shift in while disabled");
    property p_bit_len; $fell(txd_reg) && mode_q == 2'h2 && dbl_q |-> (!txd_reg) [*8] ##8 !txd_reg;
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("fixed rate bit too short");
    property p_t2_len; $fell(txd_reg) && mode_q == 2'h3 && t2tx_q |-> (!txd_reg) [*8] ##24 !txd_reg;
    endproperty
    a_t2_len: assert property (p_t2_len) else $error("timer two bit too short");
    property p_ovf_clr; sfr_rd && sfr_addr == `SPU_ADDR_BUF |=> !overwrite_err_reg; endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overwrite kept after read");
    property p_ovf_ext; $rose(overwrite_err_reg) |-> ext_q; endproperty
    a_ovf_ext: assert property (p_ovf_ext) else $error("overwrite while not extended");
    property p_cfg_rd; sfr_rd && sfr_addr == `SPU_ADDR_CFG |=>
        sfr_rdata_reg[7] == $past(overwrite_err_reg) && sfr_rdata_reg[0] == $past(ext_q); endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
    property p_pwr_rd; sfr_rd && sfr_addr == `SPU_ADDR_PWR |=> sfr_rdata_reg[7] == $past(dbl_q);
    endproperty
    a_pwr_rd: assert property (p_pwr_rd) else $error("double bit readback wrong");
endmodule // spu_uart_checker
bind spu_uart spu_uart_checker chk_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_reg(sfr_rdata_reg),
    .overwrite_err_reg(overwrite_err_reg), .rxd_oe_reg(rxd_oe_reg), .txd_reg(txd_reg)
);
`default_nettype wire

//--- tb/spu_line_model.sv
// Remote serial device on the far side of the serial pins
`timescale 1ns/100ps
`default_nettype none
module spu_line_model (
    // Clock
    input wire logic ref_clk,
    // Pins seen at the far end
    input wire logic txd,
    input wire logic rxd,
    input wire logic rxd_oe,
    output var logic line_out
);
    int          tx_bit = 16;
    int          rx_bit = 16;
    int          cap_n  = 0;
    int          n_got  = 0;
    logic [10:0] got;
    logic [7:0]  m0_got;
    logic [7:0]  m0_data;
    logic        m0_rx  = 1'b0;
    initial line_out = 1'b1;
    // Sends a frame LSB first from the start bit, then one idle bit of gap
    task automatic send(input int n, input logic [10:0] bits);
        for (int i = 0; i < n; i++) begin
            line_out <= bits[i];
            repeat (rx_bit) @(posedge ref_clk);
        end
        line_out <= 1'b1;
        repeat (rx_bit) @(posedge ref_clk);
    endtask
    // Samples mid-bit; no wait after the stop so back-to-back starts are not missed
    initial forever begin
        @(negedge txd);
        if (cap_n > 0) begin
            got = 11'h000;
            repeat (tx_bit / 2) @(posedge ref_clk);
            for (int i = 0; i < cap_n; i++) begin
                got[i] = txd;
                if (i < cap_n - 1) repeat (tx_bit) @(posedge ref_clk);
            end
            n_got++;
        end
    end
    // Shift mode: take a bit on each rising clock, offer one on each falling
    always @(posedge txd) if (rxd_oe) m0_got <= {rxd, m0_got[7:1]};
    always @(negedge txd) begin
        if (m0_rx) begin
            line_out <= m0_data[0];
            m0_data  <= m0_data >> 1;
        end
    end
endmodule // spu_line_model
`default_nettype wire

//--- tb/test_spu_uart.sv
// Self-checking bench for the four-mode serial port
`timescale 1ns/100ps
`default_nettype none
`include "spu_map.vh"
module test_spu_uart;
    logic       ref_clk;
    logic       rst_b;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_wr;
    logic       sfr_rd;
    logic       timer1_ovf;
    logic       timer2_ovf;
    logic [7:0] rv;
    wire  [7:0] sfr_rdata_reg;
    wire        tx_ready, overwrite_err_reg, rxd_out_reg, rxd_oe_reg, txd_reg, line_out;
    wire        rxd_line = rxd_oe_reg ? rxd_out_reg : line_out;
    int         n_fail = 0;
    int         check_count = 0;
    logic [7:0] addrs [6] = '{8'h87, 8'h98, 8'h99, 8'hAF, 8'hC8, 8'h10};
    spu_uart dut_u (
        .ref_clk(ref_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_reg(sfr_rdata_reg),
        .tx_ready(tx_ready), .overwrite_err_reg(overwrite_err_reg),
        .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .rxd_in(rxd_line),
        .rxd_out_reg(rxd_out_reg), .rxd_oe_reg(rxd_oe_reg), .txd_reg(txd_reg)
    );
    spu_line_model lm_u (
        .ref_clk(ref_clk), .txd(txd_reg), .rxd(rxd_line), .rxd_oe(rxd_oe_reg), .line_out(line_out)
    );
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Free-running overflow pulses every second cycle, no timer interrupt involved
    always @(posedge ref_clk) begin
        timer1_ovf <= ~timer1_ovf;
        timer2_ovf <= ~timer2_ovf;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge ref_clk);
        sfr_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge ref_clk);
        sfr_rd   <= 1'b0;
        @(negedge ref_clk);
        rv = sfr_rdata_reg;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(what, {3'h0, exp}, {3'h0, rv});
    endtask
    // Bounded waits: a hang ends the run as a mismatch
    task automatic wait_got(input int want);
        for (int k = 0; k < 20000 && lm_u.n_got < want; k++) @(posedge ref_clk);
        if (lm_u.n_got < want) begin
            n_fail++;
            $display("CHECK FAILED frames expected %0d seen %0d", want, lm_u.n_got);
            close_out();
        end
    endtask
    task automatic poll(input logic [7:0] mask);
        rv = 8'h00;
        for (int k = 0; k < 200 && (rv & mask) !== mask; k++) rd(`SPU_ADDR_CTRL);
        if ((rv & mask) !== mask) begin
            n_fail++;
            $display("CHECK FAILED flag expected %h seen %h", mask, rv);
            close_out();
        end
    endtask
    initial begin
        rst_b = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        timer1_ovf = 1'b0;
        timer2_ovf = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        foreach (addrs[i]) rdc("reset value", addrs[i], 8'h00);
        chk("tx ready", 11'h001, {10'h000, tx_ready});
        $display("test reset done");
        wr(`SPU_ADDR_PWR, 8'h80);
        wr(`SPU_ADDR_CTRL, 8'h98);
        lm_u.cap_n = 11;
        wr(`SPU_ADDR_BUF, 8'hA5);
        wait_got(1);
        chk("mode2 frame", {2'b11, 8'hA5, 1'b0}, lm_u.got);
        rdc("tx flag", `SPU_ADDR_CTRL, 8'h9A);
        rdc("double bit", `SPU_ADDR_PWR, 8'h80);
        $display("test mode2 send done");
        wr(`SPU_ADDR_CTRL, 8'h90);
        lm_u.send(11, {2'b11, 8'h3C, 1'b0});
        rdc("rx flags", `SPU_ADDR_CTRL, 8'h95);
        lm_u.send(11, {2'b10, 8'h55, 1'b0});
        rdc("unread kept", `SPU_ADDR_BUF, 8'h3C);
        wr(`SPU_ADDR_CFG, 8'h01);
        lm_u.send(11, {2'b11, 8'h66, 1'b0});
        chk("overwrite", 11'h001, {10'h000, overwrite_err_reg});
        rdc("cfg", `SPU_ADDR_CFG, 8'h81);
        rdc("overwritten", `SPU_ADDR_BUF, 8'h66);
        chk("overwrite clear", 11'h000, {10'h000, overwrite_err_reg});
        wr(`SPU_ADDR_CFG, 8'h00);
        wr(`SPU_ADDR_CTRL, 8'hB0);
        lm_u.rx_bit = 4;
        lm_u.send(9, 11'h1FE);
        lm_u.rx_bit = 16;
        lm_u.send(11, {2'b10, 8'h11, 1'b0});
        rdc("data frame filtered", `SPU_ADDR_CTRL, 8'hB0);
        lm_u.send(11, {2'b11, 8'h22, 1'b0});
        rdc("address frame", `SPU_ADDR_CTRL, 8'hB5);
        rdc("address byte", `SPU_ADDR_BUF, 8'h22);
        $display("test mode2 receive done");
        lm_u.tx_bit = 32;
        lm_u.rx_bit = 32;
        lm_u.cap_n = 10;
        wr(`SPU_ADDR_CTRL, 8'h70);
        wr(`SPU_ADDR_BUF, 8'h5A);
        wait_got(2);
        chk("mode1 frame", {2'b01, 8'h5A, 1'b0}, lm_u.got);
        lm_u.send(10, {2'b00, 8'h77, 1'b0});
        rdc("bad stop dropped", `SPU_ADDR_CTRL, 8'h72);
        lm_u.send(10, {2'b01, 8'h78, 1'b0});
        rdc("stop kept", `SPU_ADDR_CTRL, 8'h77);
        rdc("mode1 byte", `SPU_ADDR_BUF, 8'h78);
        $display("test mode1 done");
        wr(`SPU_ADDR_PWR, 8'h00);
        wr(`SPU_ADDR_T2CTRL, 8'h10);
        wr(`SPU_ADDR_CTRL, 8'hD8);
        lm_u.rx_bit = 64;
        lm_u.cap_n = 11;
        wr(`SPU_ADDR_BUF, 8'hC3);
        wait_got(3);
        chk("mode3 frame", {2'b11, 8'hC3, 1'b0}, lm_u.got);
        lm_u.send(11, {2'b10, 8'h81, 1'b0});
        rdc("mode3 rx", `SPU_ADDR_CTRL, 8'hDB);
        rdc("mode3 byte", `SPU_ADDR_BUF, 8'h81);
        rdc("t2 select", `SPU_ADDR_T2CTRL, 8'h10);
        wr(`SPU_ADDR_CTRL, 8'hD8);
        wr(`SPU_ADDR_T2CTRL, 8'h30);
        lm_u.rx_bit = 32;
        lm_u.send(11, {2'b11, 8'h42, 1'b0});
        rdc("t2 rx", `SPU_ADDR_BUF, 8'h42);
        $display("test mode3 done");
        wr(`SPU_ADDR_PWR, 8'h80);
        wr(`SPU_ADDR_T2CTRL, 8'h00);
        wr(`SPU_ADDR_CTRL, 8'h88);
        lm_u.tx_bit = 16;
        for (int i = 0; i < 18; i++) wr(`SPU_ADDR_BUF, 8'h10 + i[7:0]);
        @(negedge ref_clk);
        chk("queue full", 11'h000, {10'h000, tx_ready});
        wait_got(20);
        repeat (400) @(posedge ref_clk);
        chk("frames sent", 11'd20, lm_u.n_got[10:0]);
        chk("last frame", {2'b11, 8'h20, 1'b0}, lm_u.got);
        chk("queue drained", 11'h001, {10'h000, tx_ready});
        $display("test queue done");
        lm_u.cap_n = 0;
        wr(`SPU_ADDR_CTRL, 8'h00);
        wr(`SPU_ADDR_BUF, 8'h96);
        poll(8'h02);
        chk("shift out", {3'h0, 8'h96}, {3'h0, lm_u.m0_got});
        lm_u.m0_data = 8'hC3;
        lm_u.m0_rx = 1'b1;
        wr(`SPU_ADDR_CTRL, 8'h10);
        poll(8'h01);
        lm_u.m0_rx = 1'b0;
        rdc("shift in", `SPU_ADDR_BUF, 8'hC3);
        $display("test mode0 done");
        close_out();
    end
endmodule // test_spu_uart
`default_nettype wire
